// [fscs_pkg.sv]
// constants for the frame synchronised configuration shadow
// assumes 9-bit register addresses and 16-bit register words
package fscs_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 16;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [8:0] ADDR_MODE = 9'h0C0;
  localparam logic [8:0] ADDR_WINDOW_ENABLE_LOW = 9'h0C3;
  localparam logic [8:0] ADDR_WINDOW_ENABLE_HIGH = 9'h0C4;
  localparam logic [8:0] ADDR_BLACK_ROW_COUNT = 9'h0C5;
  localparam logic [8:0] ADDR_PADDING_ROW_COUNT = 9'h0C6;
  localparam logic [8:0] ADDR_MULT_TIMER = 9'h0C7;
  localparam logic [8:0] ADDR_FRAME_PERIOD_LENGTH = 9'h0C8;
  localparam logic [8:0] ADDR_EXPOSURE = 9'h0C9;
  localparam logic [8:0] ADDR_ROLLING_LINE_WIDTH = 9'h0CA;
  localparam logic [8:0] ADDR_GAIN_CONTROL = 9'h0CC;
  localparam logic [8:0] ADDR_FRAME_SYNC_CONTROL = 9'h0CE;
  localparam logic [8:0] ADDR_GEOM_FIRST = 9'h100;
  localparam logic [8:0] ADDR_GEOM_LAST = 9'h15F;

  // ------------------------------------------------------------------
  // mode register fields
  // ------------------------------------------------------------------
  localparam int unsigned MODE_SEQ_EN = 0;
  localparam int unsigned MODE_ROLLING = 1;
  localparam int unsigned MODE_TRIGGERED = 4;
  localparam int unsigned MODE_SLAVE = 5;
  localparam int unsigned MODE_SUBSAMPLE = 7;
  localparam int unsigned MODE_BINNING = 8;

  // ------------------------------------------------------------------
  // frame sync control fields
  // ------------------------------------------------------------------
  localparam int unsigned SYNC_LINE_WIDTH = 0;
  localparam int unsigned SYNC_BLACK = 1;
  localparam int unsigned SYNC_PADDING = 2;
  localparam int unsigned SYNC_EXPOSURE = 3;
  localparam int unsigned SYNC_GAIN = 4;
  localparam int unsigned SYNC_WINDOW = 5;
  localparam int unsigned SYNC_BLANK_WIN_SWITCH = 8;
  localparam int unsigned SYNC_EXPOSURE_MODE = 9;

  // gain control: latency compensation bit 13, gain in bits 12:0
  localparam int unsigned GAIN_LAT_COMP = 13;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_WINDOW_LOW = 16'h0001;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_SYNC = 16'h003F;

endpackage : fscs_pkg

// [fscs_hold_stage.sv]
// one word of active configuration that moves only on a load strobe
// assumes the load strobe is built on the same clock as the word
`timescale 1ns/1ps
`default_nettype none

module fscs_hold_stage #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  // keeps its old value whenever load is low: this is the freeze
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RESET_VALUE;
    end else if (load) begin
      q <= d;
    end
  end

endmodule // fscs_hold_stage

`default_nettype wire

// [fscs_frame_shadow.sv]
// staged and active register sets switched at frame boundaries
// assumes a register write port from the serial front end and a
// one-cycle frame start pulse from the sequencer, both on clk
`timescale 1ns/1ps
`default_nettype none

module fscs_frame_shadow (
  input wire logic clk,
  input wire logic srst,
  input wire logic frame_start,
  input wire logic reg_wr_en,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic geom_wr_q,
  output logic [8:0] geom_addr_q,
  output logic [15:0] geom_data_q,
  output logic act_seq_enable,
  output logic act_rolling,
  output logic act_triggered,
  output logic act_slave,
  output logic act_subsample,
  output logic act_binning,
  output logic [15:0] act_window_enable_low,
  output logic [15:0] act_window_enable_high,
  output logic [15:0] act_black_rows,
  output logic [15:0] act_padding_rows,
  output logic [15:0] act_rolling_line_width,
  output logic [15:0] act_exposure,
  output logic [15:0] act_frame_period_length,
  output logic [15:0] act_mult_timer,
  output logic [12:0] act_gain,
  output logic blank_frame,
  output logic training_pattern
);

  // ------------------------------------------------------------------
  // staged copies written by the host
  // ------------------------------------------------------------------
  logic [15:0] mode_q; // shutter and operation mode, staged
  logic [15:0] win_lo_q; // window enable low, staged
  logic [15:0] win_hi_q; // window enable high, staged
  logic [15:0] black_q; // black row count, staged
  logic [15:0] pad_q; // padding row count, staged
  logic [15:0] mult_q; // exposure timer multiplier, staged
  logic [15:0] frlen_q; // frame period length, staged
  logic [15:0] expo_q; // exposure time, staged
  logic [15:0] line_q; // rolling line width, staged
  logic [15:0] gain_q; // gain control, staged
  logic [15:0] sync_q; // frame sync control, acts at once
  logic wr_black; // write to black row count this cycle
  logic wr_pad; // write to padding row count this cycle

  assign wr_black = reg_wr_en && (reg_addr == fscs_pkg::ADDR_BLACK_ROW_COUNT);
  assign wr_pad = reg_wr_en && (reg_addr == fscs_pkg::ADDR_PADDING_ROW_COUNT);

  // every write to a mapped register lands in its staged copy, frozen or not; the freeze
  // lives only between the staged and the active copies
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= fscs_pkg::RST_MODE;
      win_lo_q <= fscs_pkg::RST_WINDOW_LOW;
      win_hi_q <= fscs_pkg::RST_ZERO;
      black_q <= fscs_pkg::RST_ZERO;
      pad_q <= fscs_pkg::RST_ZERO;
      mult_q <= fscs_pkg::RST_ZERO;
      frlen_q <= fscs_pkg::RST_ZERO;
      expo_q <= fscs_pkg::RST_ZERO;
      line_q <= fscs_pkg::RST_ZERO;
      gain_q <= fscs_pkg::RST_ZERO;
      sync_q <= fscs_pkg::RST_SYNC;
    end else if (reg_wr_en) begin
      case (reg_addr)
        fscs_pkg::ADDR_MODE: mode_q <= reg_wdata;
        fscs_pkg::ADDR_WINDOW_ENABLE_LOW: win_lo_q <= reg_wdata;
        fscs_pkg::ADDR_WINDOW_ENABLE_HIGH: win_hi_q <= reg_wdata;
        fscs_pkg::ADDR_BLACK_ROW_COUNT: black_q <= reg_wdata;
        fscs_pkg::ADDR_PADDING_ROW_COUNT: pad_q <= reg_wdata;
        fscs_pkg::ADDR_MULT_TIMER: mult_q <= reg_wdata;
        fscs_pkg::ADDR_FRAME_PERIOD_LENGTH: frlen_q <= reg_wdata;
        fscs_pkg::ADDR_EXPOSURE: expo_q <= reg_wdata;
        fscs_pkg::ADDR_ROLLING_LINE_WIDTH: line_q <= reg_wdata;
        fscs_pkg::ADDR_GAIN_CONTROL: gain_q <= reg_wdata;
        fscs_pkg::ADDR_FRAME_SYNC_CONTROL: sync_q <= reg_wdata;
        default: begin
          // geometry and unmapped addresses store nothing here
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // read back: always the staged copy
  // ------------------------------------------------------------------
  // registered one cycle after the address; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        fscs_pkg::ADDR_MODE: reg_rdata <= mode_q;
        fscs_pkg::ADDR_WINDOW_ENABLE_LOW: reg_rdata <= win_lo_q;
        fscs_pkg::ADDR_WINDOW_ENABLE_HIGH: reg_rdata <= win_hi_q;
        fscs_pkg::ADDR_BLACK_ROW_COUNT: reg_rdata <= black_q;
        fscs_pkg::ADDR_PADDING_ROW_COUNT: reg_rdata <= pad_q;
        fscs_pkg::ADDR_MULT_TIMER: reg_rdata <= mult_q;
        fscs_pkg::ADDR_FRAME_PERIOD_LENGTH: reg_rdata <= frlen_q;
        fscs_pkg::ADDR_EXPOSURE: reg_rdata <= expo_q;
        fscs_pkg::ADDR_ROLLING_LINE_WIDTH: reg_rdata <= line_q;
        fscs_pkg::ADDR_GAIN_CONTROL: reg_rdata <= gain_q;
        fscs_pkg::ADDR_FRAME_SYNC_CONTROL: reg_rdata <= sync_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // window geometry pass-through
  // ------------------------------------------------------------------
  // geometry is not frozen by any sync bit, so a resize of the active
  // window reaches the sequencer at once and may spoil one image
  always_ff @(posedge clk) begin
    if (srst) begin
      geom_wr_q <= 1'b0;
      geom_addr_q <= 9'h000;
      geom_data_q <= 16'h0000;
    end else begin
      geom_wr_q <= reg_wr_en && (reg_addr >= fscs_pkg::ADDR_GEOM_FIRST)
                   && (reg_addr <= fscs_pkg::ADDR_GEOM_LAST);
      geom_addr_q <= reg_addr;
      geom_data_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------------
  // group load strobes
  // ------------------------------------------------------------------
  logic ld_line; // line width transfer
  logic ld_black; // black row transfer
  logic ld_pad; // padding row transfer
  logic ld_expo; // exposure group transfer
  logic ld_gain; // gain group transfer
  logic ld_win; // window selection transfer
  logic expo_bypass; // triggered global master with sync mode
  logic [15:0] expo_p; // exposure one frame behind
  logic [15:0] frlen_p; // frame length one frame behind
  logic [15:0] mult_p; // multiplier one frame behind
  logic [12:0] gain_p; // gain one frame behind
  logic [12:0] gain_src; // gain feeding the active copy

  // a cleared sync bit simply withholds the frame start strobe
  assign ld_line = frame_start && sync_q[fscs_pkg::SYNC_LINE_WIDTH];
  assign ld_black = frame_start && sync_q[fscs_pkg::SYNC_BLACK];
  assign ld_pad = frame_start && sync_q[fscs_pkg::SYNC_PADDING];
  assign ld_expo = frame_start && sync_q[fscs_pkg::SYNC_EXPOSURE];
  assign ld_gain = frame_start && sync_q[fscs_pkg::SYNC_GAIN];
  assign ld_win = frame_start && sync_q[fscs_pkg::SYNC_WINDOW];

  // triggered and master only mean anything in global shutter
  assign expo_bypass = !act_rolling && act_triggered && !act_slave
                       && sync_q[fscs_pkg::SYNC_EXPOSURE_MODE];

  // ------------------------------------------------------------------
  // mode bits
  // ------------------------------------------------------------------
  // shutter, trigger and slave are static settings changed in standby,
  // so they follow the staged value directly
  always_ff @(posedge clk) begin
    if (srst) begin
      act_seq_enable <= 1'b0;
      act_rolling <= 1'b0;
      act_triggered <= 1'b0;
      act_slave <= 1'b0;
    end else begin
      act_seq_enable <= mode_q[fscs_pkg::MODE_SEQ_EN];
      act_rolling <= mode_q[fscs_pkg::MODE_ROLLING];
      act_triggered <= mode_q[fscs_pkg::MODE_TRIGGERED];
      act_slave <= mode_q[fscs_pkg::MODE_SLAVE];
    end
  end

  // subsampling and binning move with the window selection
  always_ff @(posedge clk) begin
    if (srst) begin
      act_subsample <= 1'b0;
      act_binning <= 1'b0;
    end else if (ld_win) begin
      act_subsample <= mode_q[fscs_pkg::MODE_SUBSAMPLE];
      act_binning <= mode_q[fscs_pkg::MODE_BINNING];
    end
  end

  // ------------------------------------------------------------------
  // active copies, one hold stage per word, two per exposure group word and gain word
  // ------------------------------------------------------------------
  // all stages load only on a frame start strobe, so a frame under
  // way never sees a half written group
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_WINDOW_LOW))
    u_win_lo (.clk(clk), .srst(srst), .load(ld_win), .d(win_lo_q),
              .q(act_window_enable_low));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_win_hi (.clk(clk), .srst(srst), .load(ld_win), .d(win_hi_q),
              .q(act_window_enable_high));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_black (.clk(clk), .srst(srst), .load(ld_black), .d(black_q),
             .q(act_black_rows));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_pad (.clk(clk), .srst(srst), .load(ld_pad), .d(pad_q),
           .q(act_padding_rows));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_line (.clk(clk), .srst(srst), .load(ld_line), .d(line_q),
            .q(act_rolling_line_width));

  // exposure: first stage catches staged words, second applies them a
  // frame later; the bypass feeds the staged words straight through
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_expo_p (.clk(clk), .srst(srst), .load(ld_expo), .d(expo_q),
              .q(expo_p));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_frlen_p (.clk(clk), .srst(srst), .load(ld_expo), .d(frlen_q),
               .q(frlen_p));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_mult_p (.clk(clk), .srst(srst), .load(ld_expo), .d(mult_q),
              .q(mult_p));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_expo_a (.clk(clk), .srst(srst), .load(ld_expo),
              .d(expo_bypass ? expo_q : expo_p), .q(act_exposure));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_frlen_a (.clk(clk), .srst(srst), .load(ld_expo),
               .d(expo_bypass ? frlen_q : frlen_p),
               .q(act_frame_period_length));
  fscs_hold_stage #(.WIDTH(16), .RESET_VALUE(fscs_pkg::RST_ZERO))
    u_mult_a (.clk(clk), .srst(srst), .load(ld_expo),
              .d(expo_bypass ? mult_q : mult_p), .q(act_mult_timer));

  // gain: extra frame of delay only with latency compensation set
  assign gain_src = gain_q[fscs_pkg::GAIN_LAT_COMP] ? gain_p
                    : gain_q[12:0];
  fscs_hold_stage #(.WIDTH(13), .RESET_VALUE(13'h0000))
    u_gain_p (.clk(clk), .srst(srst), .load(ld_gain), .d(gain_q[12:0]),
              .q(gain_p));
  fscs_hold_stage #(.WIDTH(13), .RESET_VALUE(13'h0000))
    u_gain_a (.clk(clk), .srst(srst), .load(ld_gain), .d(gain_src),
              .q(act_gain));

  // ------------------------------------------------------------------
  // blanking
  // ------------------------------------------------------------------
  logic black_pend_q; // black rows rewritten since last transfer
  logic pad_pend_q; // padding rows rewritten since last transfer
  logic win_switch; // staged selection differs from active one
  logic blank_d; // blank decision for the frame now starting

  // a write in the same cycle as the transfer keeps the flag set, since
  // that new value is only carried over at the following frame start
  always_ff @(posedge clk) begin
    if (srst) begin
      black_pend_q <= 1'b0;
      pad_pend_q <= 1'b0;
    end else begin
      black_pend_q <= wr_black || (black_pend_q && !ld_black);
      pad_pend_q <= wr_pad || (pad_pend_q && !ld_pad);
    end
  end

  // geometry writes never count as a switch, only selection changes
  assign win_switch = ({win_hi_q, win_lo_q}
                       != {act_window_enable_high, act_window_enable_low});

  always_comb begin
    blank_d = 1'b0;
    if (act_rolling) begin
      blank_d = (black_pend_q && ld_black) || (pad_pend_q && ld_pad)
                || (ld_win && win_switch
                    && sync_q[fscs_pkg::SYNC_BLANK_WIN_SWITCH]);
    end
  end

  // the blank decision holds for the whole frame that just started
  always_ff @(posedge clk) begin
    if (srst) begin
      blank_frame <= 1'b0;
    end else if (frame_start) begin
      blank_frame <= blank_d;
    end
  end

  // training patterns replace data on data and sync lanes while blank
  assign training_pattern = blank_frame;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_global_no_blank: assert property (
    frame_start && !act_rolling |=> !blank_frame)
    else $error("blank frame in global shutter");
  a_black_blank: assert property (
    frame_start && act_rolling && black_pend_q
    && sync_q[fscs_pkg::SYNC_BLACK] |=> blank_frame)
    else $error("black rows rewrite did not blank");
  a_black_frozen: assert property (
    frame_start && !sync_q[fscs_pkg::SYNC_BLACK]
    |=> $stable(act_black_rows))
    else $error("black rows moved while frozen");
  a_black_load: assert property (
    frame_start && sync_q[fscs_pkg::SYNC_BLACK]
    |=> act_black_rows == $past(black_q))
    else $error("black rows not loaded");
  a_expo_midframe: assert property (
    !frame_start |=> $stable(act_exposure) && $stable(act_gain))
    else $error("active value moved mid frame");
  a_expo_latency: assert property (
    frame_start && sync_q[fscs_pkg::SYNC_EXPOSURE] && !expo_bypass
    |=> act_exposure == $past(expo_p))
    else $error("exposure skipped its frame of latency");
  a_gain_direct: assert property (
    frame_start && sync_q[fscs_pkg::SYNC_GAIN]
    && !gain_q[fscs_pkg::GAIN_LAT_COMP] |=> act_gain == $past(gain_q[12:0]))
    else $error("gain not applied at frame start");
  a_win_blank: assert property (
    frame_start && act_rolling && sync_q[fscs_pkg::SYNC_WINDOW]
    && sync_q[fscs_pkg::SYNC_BLANK_WIN_SWITCH] && win_switch
    |=> blank_frame [*1] ##0 training_pattern)
    else $error("window switch did not blank");
  a_line_frozen: assert property (
    frame_start && !sync_q[fscs_pkg::SYNC_LINE_WIDTH]
    |=> $stable(act_rolling_line_width))
    else $error("line width moved while frozen");
  a_geom_pass: assert property (
    reg_wr_en && reg_addr == fscs_pkg::ADDR_GEOM_FIRST
    |=> geom_wr_q && geom_data_q == $past(reg_wdata))
    else $error("geometry write held back");

endmodule // fscs_frame_shadow

`default_nettype wire

// [fscs_host_model.sv]
// host model: register writes, reads and frame boundaries
// assumes one clk shared with the shadow block; drives 2 ns after rise
`timescale 1ns/1ps
`default_nettype none

module fscs_host_model (
  input wire logic clk,
  output logic frame_start,
  output logic reg_wr_en,
  output logic [8:0] reg_addr,
  output logic [15:0] reg_wdata
);
  // idle levels; write data is scrambled while no write is on
  initial begin
    frame_start = 1'b0;
    reg_wr_en = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 16'hA5A5;
  end

  // one-cycle write strobe, data inverted once released
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    #2;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #2;
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask

  // address held; read data valid once this returns
  task automatic rd(input logic [8:0] a);
    @(posedge clk);
    #2;
    reg_addr = a;
    @(posedge clk);
    #2;
  endtask

  // one-cycle frame boundary pulse
  task automatic fs();
    @(posedge clk);
    #2;
    frame_start = 1'b1;
    @(posedge clk);
    #2;
    frame_start = 1'b0;
  endtask
endmodule // fscs_host_model

`default_nettype wire

// [testbench.sv]
// self-checking bench for the frame synchronised config shadow
// assumes the host model drives all register and frame inputs
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk, srst, fst, wen, gwr, seq, rol, trg, slv, sub, bin, blk_f, trn;
  logic [8:0] addr, gaddr;
  logic [15:0] wd, rdat, wlo, whi, blk, pad, lw, expo, frp, mult, gdat;
  logic [15:0] r1, r2, r3, r4;
  logic [12:0] gain;
  logic [3:0] sel_q[$];
  logic [15:0] exp_q[$];
  int errors, cmp_count;

  // 25 ns clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  fscs_host_model host (.clk(clk), .frame_start(fst), .reg_wr_en(wen),
    .reg_addr(addr), .reg_wdata(wd));

  fscs_frame_shadow dut (.clk(clk), .srst(srst), .frame_start(fst),
    .reg_wr_en(wen), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
    .geom_wr_q(gwr), .geom_addr_q(gaddr), .geom_data_q(gdat),
    .act_seq_enable(seq), .act_rolling(rol), .act_triggered(trg),
    .act_slave(slv), .act_subsample(sub), .act_binning(bin),
    .act_window_enable_low(wlo), .act_window_enable_high(whi),
    .act_black_rows(blk), .act_padding_rows(pad),
    .act_rolling_line_width(lw), .act_exposure(expo),
    .act_frame_period_length(frp), .act_mult_timer(mult),
    .act_gain(gain), .blank_frame(blk_f), .training_pattern(trn));

  // output picked by a selector code
  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = rdat;
      4'h1: obs = wlo;
      4'h2: obs = blk;
      4'h3: obs = pad;
      4'h4: obs = lw;
      4'h5: obs = expo;
      4'h6: obs = frp;
      4'h7: obs = mult;
      4'h8: obs = {3'h0, gain};
      4'h9: obs = {14'h0000, trn, blk_f};
      4'hA: obs = {14'h0000, bin, sub};
      4'hB: obs = {12'h000, slv, trg, rol, seq};
      4'hC: obs = gdat;
      4'hD: obs = whi;
      4'hE: obs = {gwr, 6'h00, gaddr};
      default: obs = {15'h0000, gwr};
    endcase
  endfunction

  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // note an expectation; the watcher compares at the next falling edge
  task automatic chk(input logic [3:0] s, input logic [15:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
    @(negedge clk);
    #1;
  endtask

  // watcher: outputs are settled mid-cycle
  always @(negedge clk) begin
    if (sel_q.size() > 0) begin
      cmp(obs(sel_q.pop_front()), exp_q.pop_front());
    end
  end

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    #2500000;
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    srst = 1'b1;
    r1 = $urandom(95692);
    r1 = $urandom();
    r2 = $urandom();
    r3 = $urandom();
    r4 = $urandom();
    repeat (12) @(posedge clk);
    #2;
    srst = 1'b0;
    chk(4'h1, 16'h0001);
    chk(4'h9, 16'h0000);
    host.rd(9'h0CE);
    chk(4'h0, 16'h003F);
    host.rd(9'h0FF);
    chk(4'h0, 16'h0000);
    // global shutter: staged only until frame start, no blank
    host.wr(9'h0C5, 16'h0005);
    host.rd(9'h0C5);
    chk(4'h0, 16'h0005);
    chk(4'h2, 16'h0000);
    host.fs();
    chk(4'h2, 16'h0005);
    chk(4'h9, 16'h0000);
    // rolling shutter: row rewrites blank one frame
    host.wr(9'h0C0, 16'h0002);
    // mode bits follow the staged copy one cycle after the write edge
    @(posedge clk);
    chk(4'hB, 16'h0002);
    host.wr(9'h0C6, 16'h0003);
    host.fs();
    chk(4'h3, 16'h0003);
    chk(4'h9, 16'h0003);
    host.fs();
    chk(4'h9, 16'h0000);
    host.wr(9'h0C5, 16'h0005);
    host.fs();
    chk(4'h9, 16'h0003);
    // freeze padding and exposure, load, release
    host.wr(9'h0CE, 16'h0033);
    host.wr(9'h0C6, 16'h0009);
    host.wr(9'h0C9, 16'h0007);
    host.wr(9'h0C8, r1);
    host.wr(9'h0C7, r2);
    host.fs();
    chk(4'h3, 16'h0003);
    chk(4'h5, 16'h0000);
    host.rd(9'h0C6);
    chk(4'h0, 16'h0009);
    host.wr(9'h0CE, 16'h003F);
    host.fs();
    chk(4'h3, 16'h0009);
    chk(4'h5, 16'h0000);
    host.fs();
    chk(4'h5, 16'h0007);
    chk(4'h6, r1);
    chk(4'h7, r2);
    // gain, with and without latency compensation, then frozen
    host.wr(9'h0CC, 16'h0055);
    host.fs();
    chk(4'h8, 16'h0055);
    host.wr(9'h0CC, 16'h20AA);
    host.fs();
    chk(4'h8, 16'h0055);
    host.fs();
    chk(4'h8, 16'h00AA);
    host.wr(9'h0CE, 16'h002F);
    host.wr(9'h0CC, 16'h0011);
    host.fs();
    host.fs();
    chk(4'h8, 16'h00AA);
    // window switch blanking and resize without blanking
    host.wr(9'h0CE, 16'h013F);
    host.wr(9'h0C0, 16'h0082);
    host.wr(9'h0C3, 16'h0002);
    chk(4'h1, 16'h0001);
    host.fs();
    chk(4'h1, 16'h0002);
    chk(4'hA, 16'h0001);
    chk(4'h9, 16'h0003);
    host.wr(9'h0C3, 16'h0002);
    host.fs();
    chk(4'h9, 16'h0000);
    host.wr(9'h0CE, 16'h011F);
    host.wr(9'h105, r3);
    chk(4'hE, 16'h8105);
    // data is registered with the strobe; write again to look at it
    host.wr(9'h105, r3);
    chk(4'hC, r3);
    host.wr(9'h0C4, 16'h00F0);
    host.fs();
    chk(4'hD, 16'h0000);
    // line width gate
    host.wr(9'h0CE, 16'h003E);
    host.wr(9'h0CA, r4);
    host.fs();
    chk(4'h4, 16'h0000);
    host.wr(9'h0CE, 16'h003F);
    host.fs();
    chk(4'h4, r4);
    // triggered global master with exposure sync mode: no latency
    host.wr(9'h0C0, 16'h0010);
    host.wr(9'h0CE, 16'h023F);
    chk(4'hB, 16'h0004);
    host.wr(9'h0C9, 16'h0033);
    host.wr(9'h0C5, 16'h0009);
    host.fs();
    chk(4'h5, 16'h0033);
    chk(4'h9, 16'h0000);
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
